// [shw_checker_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module shw_checker #(
    parameter int RECOVERY_CYCLES = 20,
    parameter int POWER_UP_CYCLES = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic pause_n,
    input wire logic so_oe,
    input wire logic latch_status,
    input wire logic protect_status,
    input wire logic [1:0] guard_status,
    input wire logic paused,
    input wire logic asleep,
    input wire logic access_ready,
    input wire logic write_refused
);
    int up_cnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            up_cnt <= 0;
        else if (up_cnt < POWER_UP_CYCLES)
            up_cnt <= up_cnt + 1;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_float_when_paused: assert property ((!pause_n || cs_n) |-> !so_oe)
        else $error("so driven while paused or deselected");
    a_pause_enters: assert property ((!pause_n && !cs_n) [*6] |-> paused)
        else $error("pause not taken");
    a_pause_leaves: assert property ((pause_n || cs_n) [*6] |-> !paused)
        else $error("pause not left");
    a_open_write_refused: assert property (
        write_refused && latch_status |-> protect_status || guard_status != 2'h0)
        else $error("write refused with nothing guarded");
    a_wake_waits: assert property ($fell(asleep) |-> (!access_ready) [*8])
        else $error("ready too soon after wake");
    a_power_up_wait: assert property (access_ready |-> up_cnt >= POWER_UP_CYCLES)
        else $error("ready before power-up wait");
    a_status_quiet: assert property (cs_n [*8] |-> $stable(latch_status) && $stable(guard_status))
        else $error("status changed outside a frame");
    a_refuse_pulse: assert property (write_refused |=> !write_refused)
        else $error("refusal pulse too long");
    c_paused: cover property ($rose(paused));
    c_refused: cover property (write_refused);
    c_woken: cover property ($fell(asleep));
endmodule // shw_checker
bind shw_core shw_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES), .POWER_UP_CYCLES(POWER_UP_CYCLES))
    shw_checker_inst (.clk(clk), .resetn(resetn), .cs_n(cs_n), .pause_n(pause_n),
    .so_oe(so_oe), .latch_status(latch_status), .protect_status(protect_status),
    .guard_status(guard_status), .paused(paused), .asleep(asleep),
    .access_ready(access_ready), .write_refused(write_refused));
`default_nettype wire

// [shw_core.sv]
// What this block does
// - latch clear refuses every array and status write
// - latch set, protect clear: status and unguarded array writable
// - protect set, pin low: status write blocked
// - protect set, pin high: status writable; guards stay
// - pause suspends command, keeping its progress
// - paused: clock edges and data input ignored
// - paused during reads: data output floats
// - select rising while paused aborts command
// - abort before opcode keeps latch value
// - latch set/cleared by commands, power-on, wake
// - guard bits select protected upper range
`timescale 1ns/1ps
`default_nettype none
module shw_core #(
    parameter int AW = 19,
    parameter logic [31:0] DEVICE_ID = 32'h5a5a_0001, // arbitrary value
    parameter int RECOVERY_CYCLES = shw_pkg::WAKE_RECOVERY_CYCLES,
    parameter int POWER_UP_CYCLES = shw_pkg::POWER_UP_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic pause_n,
    input wire logic write_protect_n,
    output logic so_out,
    output logic so_oe,
    output logic latch_status,
    output logic protect_status,
    output logic [1:0] guard_status,
    output logic paused,
    output logic asleep,
    output logic access_ready,
    output logic write_refused
);
    // ---------------- link domain (sck) ----------------
    logic [7:0] mem [0:(1 << AW) - 1];
    logic [5:0] cnt_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic [7:0] op_reg;
    logic [AW-1:0] addr_reg;
    logic wel_reg;
    logic spe_reg;
    logic [2:0] spare_reg;
    logic [1:0] guard_reg;
    logic wp_meta_reg;
    logic wp_reg;
    logic arm_tog_reg;
    logic arm_seen_reg;
    logic sleep_reg;
    logic woke_tog_reg;
    logic woke_seen_reg;
    logic refuse_tog_reg;
    logic [31:0] out_reg;
    logic so_reg;
    logic oe_reg;

    // frame counters are held clear whenever select is high
    wire frame_rst = cs_n | ~resetn;
    wire run = pause_n & ~sleep_reg;
    wire quiet = cs_n | ~pause_n | ~resetn;
    wire [7:0] sh_next = {shift_reg[6:0], si};
    wire [5:0] cnt_next = (cnt_reg == shw_pkg::CNT_MAX) ? cnt_reg : cnt_reg + 6'h01;
    // a wake clears the latch through a toggle pair, so only this domain writes it
    wire wel_eff = wel_reg & (woke_tog_reg == woke_seen_reg);
    // sleep arm: set by the opcode, cancelled by any later unpaused clock edge
    wire arm_pending = arm_tog_reg != arm_seen_reg;
    wire [7:0] status_byte = {spe_reg, spare_reg, guard_reg, wel_eff, 1'b0};
    wire is_fast = op_reg == shw_pkg::OP_FAST_READ;
    wire is_mread = (op_reg == shw_pkg::OP_MEM_READ) | is_fast;
    wire is_mwrite = op_reg == shw_pkg::OP_MEM_WRITE;
    wire is_sread = op_reg == shw_pkg::OP_STATUS_READ;
    wire is_swrite = op_reg == shw_pkg::OP_STATUS_WRITE;
    wire is_id = op_reg == shw_pkg::OP_ID_READ;
    wire [5:0] data_start = is_fast ? shw_pkg::DUMMY_END
        : (is_sread | is_swrite | is_id) ? shw_pkg::STATUS_DATA : shw_pkg::ADDR_END;
    wire in_data = cnt_reg >= data_start;
    wire byte_done = run & (bit_reg == 3'h7) & in_data;
    // protected ranges scale with the top two address bits
    wire [1:0] top2 = addr_reg[AW-1:AW-2];
    wire guarded = (guard_reg == shw_pkg::GUARD_ALL)
        | ((guard_reg == shw_pkg::GUARD_HALF) & top2[1])
        | ((guard_reg == shw_pkg::GUARD_QUARTER) & (top2 == 2'h3));
    wire array_ok = wel_eff & ~guarded;
    wire status_ok = wel_eff & (~spe_reg | wp_reg);
    wire do_mwrite = byte_done & is_mwrite & array_ok;
    wire do_swrite = byte_done & is_swrite & status_ok;
    wire refused = byte_done & ((is_mwrite & ~array_ok) | (is_swrite & ~status_ok));
    // opcode is recognised at its eighth rising edge
    wire op_done = run & (cnt_reg == shw_pkg::OPCODE_LAST);

    // frame state: cleared when select rises, even mid-pause
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_reg <= 6'h00;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            op_reg <= 8'h00;
            addr_reg <= '0;
        end else if (run) begin
            cnt_reg <= cnt_next;
            bit_reg <= bit_reg + 3'h1;
            shift_reg <= sh_next;
            if (op_done) begin
                op_reg <= sh_next;
            end
            if (cnt_reg >= shw_pkg::STATUS_DATA && cnt_reg < shw_pkg::ADDR_END) begin
                addr_reg <= {addr_reg[AW-2:0], si};
            end else if (byte_done & (is_mread | is_mwrite)) begin
                addr_reg <= addr_reg + 1'b1;
            end
        end
    end

    // persistent state: survives frames, reset only at power-on
    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            wel_reg <= 1'b0;
            spe_reg <= shw_pkg::STATUS_RESET[shw_pkg::ST_PROTECT];
            spare_reg <= shw_pkg::STATUS_RESET[shw_pkg::ST_SPARE_HI:shw_pkg::ST_SPARE_LO];
            guard_reg <= shw_pkg::STATUS_RESET[shw_pkg::ST_GUARD_HI:shw_pkg::ST_GUARD_LO];
            wp_meta_reg <= 1'b0;
            wp_reg <= 1'b0;
            arm_tog_reg <= 1'b0;
            woke_seen_reg <= 1'b0;
            refuse_tog_reg <= 1'b0;
        end else begin
            wp_meta_reg <= write_protect_n;
            wp_reg <= wp_meta_reg;
            if (woke_tog_reg != woke_seen_reg) begin
                woke_seen_reg <= woke_tog_reg;
                wel_reg <= 1'b0;
            end else if (op_done && sh_next == shw_pkg::OP_LATCH_SET) begin
                wel_reg <= 1'b1;
            end else if (op_done && sh_next == shw_pkg::OP_LATCH_CLEAR) begin
                wel_reg <= 1'b0;
            end
            if (!cs_n && run) begin
                if (op_done && sh_next == shw_pkg::OP_SLEEP) begin
                    arm_tog_reg <= ~arm_seen_reg;
                end else if (arm_pending) begin
                    arm_tog_reg <= arm_seen_reg;
                end
            end
            if (!cs_n && do_swrite) begin
                spe_reg <= sh_next[shw_pkg::ST_PROTECT];
                spare_reg <= sh_next[shw_pkg::ST_SPARE_HI:shw_pkg::ST_SPARE_LO];
                guard_reg <= sh_next[shw_pkg::ST_GUARD_HI:shw_pkg::ST_GUARD_LO];
            end
            if (!cs_n && refused) begin
                refuse_tog_reg <= ~refuse_tog_reg;
            end
        end
    end

    // array byte lands on the rising edge of its last data bit
    always_ff @(posedge sck) begin
        if (!cs_n && do_mwrite) begin
            mem[addr_reg] <= sh_next;
        end
    end

    // sleep entry and exit both at select rising; select falling while asleep only clears the latch
    always_ff @(posedge cs_n or negedge resetn) begin
        if (!resetn) begin
            sleep_reg <= 1'b0;
            arm_seen_reg <= 1'b0;
        end else begin
            sleep_reg <= ~sleep_reg & arm_pending;
            arm_seen_reg <= arm_tog_reg;
        end
    end

    always_ff @(negedge cs_n or negedge resetn) begin
        if (!resetn) begin
            woke_tog_reg <= 1'b0;
        end else if (sleep_reg) begin
            woke_tog_reg <= ~woke_tog_reg;
        end
    end

    // data out changes on falling clock edges
    wire reading = is_mread | is_sread | is_id;
    wire load = reading & in_data & (bit_reg == 3'h0);
    wire [31:0] load_word = is_id ? DEVICE_ID
        : {(is_sread ? status_byte : mem[addr_reg]), 24'h000000};
    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            out_reg <= 32'h00000000;
            so_reg <= 1'b0;
        end else if (run) begin
            if (load && (!is_id || cnt_reg == data_start)) begin
                out_reg <= load_word;
                so_reg <= load_word[31];
            end else begin
                out_reg <= {out_reg[30:0], out_reg[0]};
                so_reg <= out_reg[30];
            end
        end
    end

    // enable drops at once on deselect or pause, returns on a falling edge
    always_ff @(negedge sck or posedge quiet) begin
        if (quiet) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= run & reading & in_data;
        end
    end

    assign so_out = so_reg;
    assign so_oe = oe_reg;

    // ---------------- system domain (clk) ----------------
    logic rst_meta_reg;
    logic rst_reg;
    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    logic refuse_d_reg;
    logic refused_reg;
    logic [1:0] guard_out_reg;
    logic latch_out_reg;
    logic protect_out_reg;
    logic paused_out_reg;
    logic asleep_out_reg;
    logic [15:0] wait_reg;
    logic ready_reg;
    logic spe_m_reg;
    logic spe_q_reg;

    // levels cross through two flops; a refusal crosses as a toggle
    wire [5:0] cross_in = {refuse_tog_reg, ~pause_n & ~cs_n, sleep_reg, guard_reg, wel_eff};
    // the end of sleep restarts the recovery wait
    wire recovering = asleep_out_reg & ~s2_reg[3];
    wire [15:0] wait_next = recovering ? RECOVERY_CYCLES[15:0]
        : (wait_reg != 16'h0000) ? wait_reg - 16'h0001 : wait_reg;

    // reset leaves this domain only after two clock edges
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_reg <= rst_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_reg) begin
        if (!rst_reg) begin
            s1_reg <= 6'h00;
            s2_reg <= 6'h00;
            refuse_d_reg <= 1'b0;
            refused_reg <= 1'b0;
            latch_out_reg <= 1'b0;
            protect_out_reg <= 1'b0;
            guard_out_reg <= 2'h0;
            paused_out_reg <= 1'b0;
            asleep_out_reg <= 1'b0;
            wait_reg <= POWER_UP_CYCLES[15:0];
            ready_reg <= 1'b0;
        end else begin
            s1_reg <= cross_in;
            s2_reg <= s1_reg;
            refuse_d_reg <= s2_reg[5];
            refused_reg <= s2_reg[5] ^ refuse_d_reg;
            latch_out_reg <= s2_reg[0];
            guard_out_reg <= s2_reg[2:1];
            paused_out_reg <= s2_reg[4];
            asleep_out_reg <= s2_reg[3];
            protect_out_reg <= spe_q_reg;
            wait_reg <= wait_next;
            ready_reg <= ~s2_reg[3] & ~recovering & (wait_next == 16'h0000);
        end
    end

    // protect bit crosses as a level too
    always_ff @(posedge clk or negedge rst_reg) begin
        if (!rst_reg) begin
            spe_m_reg <= 1'b0;
            spe_q_reg <= 1'b0;
        end else begin
            spe_m_reg <= spe_reg;
            spe_q_reg <= spe_m_reg;
        end
    end

    assign latch_status = latch_out_reg;
    assign protect_status = protect_out_reg;
    assign guard_status = guard_out_reg;
    assign paused = paused_out_reg;
    assign asleep = asleep_out_reg;
    assign access_ready = ready_reg;
    assign write_refused = refused_reg;
endmodule // shw_core
`default_nettype wire

// [shw_host.sv]
`timescale 1ns/1ps
`default_nettype none
module shw_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic pause_n,
    input wire logic so_out,
    input wire logic so_oe
);
    logic so_float, oe_pre, oe_in;
    // a released data line shows no stale value
    always @(sck) so_float <= so_oe ? ~so_out : ~so_float;
    initial begin
        {sck, cs_n, si, pause_n, so_float, oe_pre, oe_in} = 7'h38;
    end
    task automatic start();
        cs_n = 0;
        #20;
    endtask
    task automatic stop();
        #15 cs_n = 1;
        #60;
    endtask
    // junk clocked while paused; released with sck at its entry level
    task automatic hold();
        // pause entry keeps clear of the falling edge just made
        #5;
        oe_pre = so_oe;
        oe_in = 0;
        pause_n = 0;
        repeat (4) begin
            si = ~si;
            #15 sck = 1;
            oe_in = oe_in | so_oe;
            #15 sck = 0;
        end
        #200 pause_n = 1;
        #20;
    endtask
    task automatic xb(input logic [7:0] tx, input int n, input int pz, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            if (i == pz)
                hold();
            si = tx[i];
            #15 sck = 1;
            rx[i] = so_oe ? so_out : so_float;
            #15 sck = 0;
        end
    endtask
    // rest of the opcode is clocked while paused and must be ignored
    task automatic abort(input logic [3:0] rest);
        #5 pause_n = 0;
        for (int i = 3; i >= 0; i--) begin
            si = rest[i];
            #15 sck = 1;
            #15 sck = 0;
        end
        #20 cs_n = 1;
        #30 pause_n = 1;
        #60;
    endtask
endmodule // shw_host
`default_nettype wire

// [shw_pkg.sv]
package shw_pkg;
    // op-codes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE = 8'h02;
    localparam logic [7:0] OP_ID_READ = 8'h9f;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_SLEEP = 8'hb9;
    // frame bit positions: opcode end, address end, fast-read dummy end
    localparam logic [5:0] OPCODE_LAST = 6'h07;
    localparam logic [5:0] ADDR_END = 6'h20;
    localparam logic [5:0] DUMMY_END = 6'h28;
    localparam logic [5:0] STATUS_DATA = 6'h08;
    localparam logic [5:0] CNT_MAX = 6'h3f;
    // status byte layout
    localparam int ST_PROTECT = 7;
    localparam int ST_SPARE_HI = 6;
    localparam int ST_SPARE_LO = 4;
    localparam int ST_GUARD_HI = 3;
    localparam int ST_GUARD_LO = 2;
    localparam int ST_LATCH = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // region guard encodings
    localparam logic [1:0] GUARD_NONE = 2'h0;
    localparam logic [1:0] GUARD_QUARTER = 2'h1;
    localparam logic [1:0] GUARD_HALF = 2'h2;
    localparam logic [1:0] GUARD_ALL = 2'h3;
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int WAKE_RECOVERY_US = 400;
    localparam int POWER_UP_US = 250;
    localparam int WAKE_RECOVERY_CYCLES = (WAKE_RECOVERY_US * 1000) / CLK_PERIOD_NS;
    localparam int POWER_UP_CYCLES = (POWER_UP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, resetn, write_protect_n, latch_status, protect_status, paused, asleep;
    logic access_ready, write_refused, pause_seen;
    logic [1:0] guard_status;
    logic [7:0] rx;
    wire logic sck, cs_n, si, pause_n, so_out, so_oe;
    int err_count, tests_run, refusals, base;
    shw_core #(.AW(10), .RECOVERY_CYCLES(20), .POWER_UP_CYCLES(10)) shw_core_inst (
        .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n),
        .write_protect_n(write_protect_n), .so_out(so_out), .so_oe(so_oe),
        .latch_status(latch_status), .protect_status(protect_status),
        .guard_status(guard_status), .paused(paused), .asleep(asleep),
        .access_ready(access_ready), .write_refused(write_refused));
    shw_host shw_host_inst (.sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n),
        .so_out(so_out), .so_oe(so_oe));
    initial clk = 0;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        refusals += (write_refused === 1'b1);
        pause_seen |= (paused === 1'b1);
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask
    task automatic refchk(input int n);
        check("refusals", 8'(base + n), 8'(refusals));
        base = refusals;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (access_ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check("access_ready", 8'h01, {7'h00, access_ready});
        if (access_ready !== 1'b1)
            conclude();
    endtask
    task automatic two(input logic [7:0] op, input logic [7:0] d, input int n);
        shw_host_inst.start();
        shw_host_inst.xb(op, 8, -1, rx);
        shw_host_inst.xb(d, n, -1, rx);
        shw_host_inst.stop();
        settle();
    endtask
    task automatic mem(input logic [7:0] op, input logic [9:0] a, input logic [7:0] d,
        input int pa, input int pd);
        shw_host_inst.start();
        shw_host_inst.xb(op, 8, -1, rx);
        shw_host_inst.xb(8'h00, 8, -1, rx);
        shw_host_inst.xb({6'h00, a[9:8]}, 8, -1, rx);
        shw_host_inst.xb(a[7:0], 8, pa, rx);
        shw_host_inst.xb(d, 8, pd, rx);
        shw_host_inst.stop();
        settle();
    endtask
    initial begin
        {resetn, write_protect_n, pause_seen} = 3'h2;
        {err_count, tests_run, refusals, base} = 128'h0;
        repeat (8) @(negedge clk);
        resetn = 1;
        wait_ready();
        mem(shw_pkg::OP_MEM_WRITE, 10'h010, 8'h5a, -1, -1);
        two(shw_pkg::OP_STATUS_WRITE, 8'h8c, 8);
        refchk(2);
        check("protect", 8'h00, {7'h00, protect_status});
        two(shw_pkg::OP_LATCH_SET, 8'h00, 0);
        check("latch", 8'h01, {7'h00, latch_status});
        for (int g = 0; g < 4; g++) begin
            two(shw_pkg::OP_STATUS_WRITE, {4'h0, 2'(g), 2'h0}, 8);
            check("guard", 8'(g), {6'h00, guard_status});
            mem(shw_pkg::OP_MEM_WRITE, 10'h3ff, 8'ha5, -1, -1);
            mem(shw_pkg::OP_MEM_WRITE, 10'h280, 8'ha5, -1, -1);
            mem(shw_pkg::OP_MEM_WRITE, 10'h000, 8'ha5, -1, -1);
            refchk(g);
        end
        @(negedge clk) write_protect_n = 0;
        two(shw_pkg::OP_STATUS_WRITE, 8'h80, 8);
        check("protect", 8'h01, {7'h00, protect_status});
        two(shw_pkg::OP_STATUS_WRITE, 8'h84, 8);
        mem(shw_pkg::OP_MEM_WRITE, 10'h155, 8'h3c, -1, 3);
        refchk(1);
        check("guard", 8'h00, {6'h00, guard_status});
        mem(shw_pkg::OP_MEM_READ, 10'h155, 8'h00, 4, -1);
        check("read", 8'h3c, rx);
        shw_host_inst.start();
        shw_host_inst.xb(shw_pkg::OP_FAST_READ, 8, -1, rx);
        shw_host_inst.xb(8'h00, 8, -1, rx);
        shw_host_inst.xb(8'h01, 8, -1, rx);
        shw_host_inst.xb(8'h55, 8, -1, rx);
        shw_host_inst.xb(8'h00, 8, 5, rx);
        shw_host_inst.xb(8'h00, 8, -1, rx);
        check("fast read", 8'h3c, rx);
        shw_host_inst.stop();
        settle();
        check("paused", 8'h01, {7'h00, pause_seen});
        @(negedge clk) write_protect_n = 1;
        two(shw_pkg::OP_STATUS_WRITE, 8'h88, 8);
        mem(shw_pkg::OP_MEM_WRITE, 10'h300, 8'h11, -1, -1);
        refchk(1);
        shw_host_inst.start();
        shw_host_inst.xb(shw_pkg::OP_STATUS_READ, 8, -1, rx);
        shw_host_inst.xb(8'h00, 8, -1, rx);
        check("status", 8'h8a, rx);
        shw_host_inst.xb(8'h00, 1, 7, rx);
        check("oe", 8'h02, {6'h00, shw_host_inst.oe_pre, shw_host_inst.oe_in});
        shw_host_inst.stop();
        shw_host_inst.start();
        shw_host_inst.xb(shw_pkg::OP_LATCH_CLEAR, 4, -1, rx);
        shw_host_inst.abort(4'h4);
        settle();
        check("latch", 8'h01, {7'h00, latch_status});
        two(shw_pkg::OP_LATCH_CLEAR, 8'h00, 0);
        check("latch", 8'h00, {7'h00, latch_status});
        two(shw_pkg::OP_LATCH_SET, 8'h00, 0);
        two(shw_pkg::OP_SLEEP, 8'h00, 0);
        check("asleep", 8'h01, {7'h00, asleep});
        shw_host_inst.start();
        shw_host_inst.stop();
        settle();
        check("ready", 8'h00, {7'h00, access_ready});
        wait_ready();
        check("latch", 8'h00, {7'h00, latch_status});
        conclude();
    end
endmodule // testbench
`default_nettype wire
